// ### verilog/lfb_pkg.sv
// Purpose: Shared constants and carriers for the LCD frame and blink controller
// Assumes: APB with 32-bit data, 40 MHz pclk
// Notes:   Register byte address is four times the register index
package lfb_pkg;
   // Register indices and byte addresses
   localparam logic [7:0]  IDX_PRIMARY = 8'h95;
   localparam logic [7:0]  IDX_CLKBLK  = 8'h96;
   localparam logic [7:0]  IDX_FRMUPD  = 8'hB1;
   localparam logic [7:0]  IDX_STATUS  = 8'hB8;
   localparam logic [7:0]  IDX_MASK    = 8'hB9;
   localparam logic [11:0] ADDR_PRIMARY = {2'b00, IDX_PRIMARY, 2'b00};
   localparam logic [11:0] ADDR_CLKBLK  = {2'b00, IDX_CLKBLK, 2'b00};
   localparam logic [11:0] ADDR_FRMUPD  = {2'b00, IDX_FRMUPD, 2'b00};
   localparam logic [11:0] ADDR_STATUS  = {2'b00, IDX_STATUS, 2'b00};
   localparam logic [11:0] ADDR_MASK    = {2'b00, IDX_MASK, 2'b00};

   // Reset values
   localparam logic [7:0] RST_PRIMARY = 8'h00;
   localparam logic [7:0] RST_CLKBLK  = 8'h00;
   localparam logic [7:0] RST_FRMUPD  = 8'h00;
   localparam logic [1:0] RST_MASK    = 2'b00;

   // Frame update control fields
   localparam int FU_INV  = 6;
   localparam int FU_UPD  = 1;
   localparam int FU_HOLD = 0;
   localparam logic [7:0] FU_WMASK = 8'h41;

   // Clock and blink config fields
   localparam int CB_SRC_HI  = 7;
   localparam int CB_SRC_LO  = 6;
   localparam int CB_RATE_HI = 5;
   localparam int CB_RATE_LO = 4;
   localparam int CB_FD_HI   = 3;
   localparam int CB_FD_LO   = 0;

   // Primary config fields (subset used here)
   localparam int PC_BLINK  = 5;
   localparam int PC_CLKSEL = 3;
   localparam int PC_MUX_HI = 1;
   localparam int PC_MUX_LO = 0;
   localparam logic [7:0] PC_WMASK = 8'h2B;

   // Status and mask bits
   localparam int ST_UPD   = 0;
   localparam int ST_FRAME = 1;

   // Blink source and multiplex codes
   localparam logic [1:0] BLK_SW_OFF = 2'b00;
   localparam logic [1:0] BLK_SW_ON  = 2'b01;
   localparam logic [1:0] BLK_FIXED  = 2'b10;
   localparam logic [1:0] BLK_RATE   = 2'b11;
   localparam logic [1:0] MUX_3      = 2'b10;
   localparam logic [1:0] MUX_4      = 2'b11;

   // Timing: LCD base clock from pclk
   localparam int CLK_HZ        = 40000000;
   localparam int LCD_BASE_HZ   = 2048;
   localparam int LCD_TICK_CYC  = CLK_HZ / LCD_BASE_HZ;
   localparam logic [3:0] SLOW_DIV_LAST = 4'hF;

   // Blink half periods, in base ticks
   localparam logic [12:0] BLK_HALF_2HZ  = 13'h0200;
   localparam logic [12:0] BLK_HALF_1HZ  = 13'h0400;
   localparam logic [12:0] BLK_HALF_H2HZ = 13'h0800;
   localparam logic [12:0] BLK_HALF_H3HZ = 13'h0C00;
   localparam logic [12:0] BLK_HALF_H4HZ = 13'h1000;

   // Drive divisors for frame divider code 0
   localparam logic [7:0] DIV0_MUX2 = 8'h80;
   localparam logic [7:0] DIV0_MUX34 = 8'h40;
   // Three-way code 1 drives at 2048/6, not the four-way 2048/4
   localparam logic [7:0] DIV1_MUX3 = 8'h06;

   typedef struct packed {
      logic       drive_tick;
      logic       frame_start;
      logic [1:0] com_phase;
      logic       frame_invert;
      logic       display_on;
      logic       load_strobe;
      logic       mem_hold;
   } lfb_drive_s;
endpackage

// ### verilog/lfb_ctrl.sv
// Purpose: LCD frame timing, blink and display memory handover control
// Assumes: APB slave on pclk; no other clock domain
// Notes:   Zero-wait APB; 128 Hz source reuses the 2048 Hz divisor formulas
// Operation
// [RL1] Software keeps config bit seven zero
// [RL2] Inversion enabled: invert alternate frames
// [RL3] Software keeps config bits five to two zero
// [RL4] Set update flag after load and frame start
// [RL5] Hold bit set: stop taking display data
// [RL6] Hold cleared: load at next frame boundary
// [RL7] Software sets hold, rewrites, then clears
// [RL8] Blink source 00: display held off
// [RL9] Blink source 01: display held on
// [RL10] Blink source 10: fixed two hertz blink
// [RL11] Blink source 11: rate from rate field
// [RL12] Rate field: 1, 1/2, 1/3, 1/4 hertz
// [RL13] Frame divider sets frame rate, default zero
// [RL14] Two-way mux: drive 2048/(4(code+1)); code 0 here drives 2048/128
// [RL15] Four-way mux: drive 2048/(2(code+1)); code 0 here drives 2048/64
// [RL16] Software avoids out-of-range divider codes
// [RL17] Blink settings act only with blink enable
// [RL18] Three-way mux: four-way drive, third frame; code 1 here drives 2048/6 and frames every second step
`timescale 1ns/1ps
`default_nettype none
module lfb_ctrl #(
   parameter int TICK_CYC = lfb_pkg::LCD_TICK_CYC
) (
   // Clock and reset
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   // APB slave
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [11:0]          paddr,
   input  wire logic [31:0]          pwdata,
   output var  logic [31:0]          prdata,
   output var  logic                 pready,
   output var  logic                 pslverr,
   // LCD drive control
   output var  lfb_pkg::lfb_drive_s  drive,
   // Interrupt
   output var  logic                 irq
);
   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
      logic [7:0]  frmupd;
      logic [7:0]  clkblk;
      logic [7:0]  primary;
      logic [1:0]  mask;
      logic [1:0]  stat;
      logic        irq;
      logic [14:0] pre_cnt;
      logic [3:0]  slow_cnt;
      logic [7:0]  div_cnt;
      logic        load_pend;
      logic [12:0] blk_cnt;
      logic        blk_phase;
      lfb_pkg::lfb_drive_s drv;
   } lfb_state_s;

   localparam logic [14:0] TICK_LAST = 15'(TICK_CYC - 1);

   lfb_state_s st_ff;
   lfb_state_s nxt_st;

   logic        base_tick;
   logic        lcd_tick;
   logic [3:0]  fd_code;
   logic [4:0]  fd_plus;
   logic [1:0]  mux;
   logic [7:0]  drive_div;
   logic [1:0]  last_phase;
   logic [12:0] blk_half;
   logic        setup;
   logic        access;
   logic        hit;
   logic [7:0]  rd_val;

   always_comb begin
      fd_code  = st_ff.clkblk[lfb_pkg::CB_FD_HI:lfb_pkg::CB_FD_LO];
      mux      = st_ff.primary[lfb_pkg::PC_MUX_HI:lfb_pkg::PC_MUX_LO];
      base_tick = (st_ff.pre_cnt >= TICK_LAST);
      // 128 Hz source is every sixteenth base tick
      lcd_tick = base_tick &
                 (!st_ff.primary[lfb_pkg::PC_CLKSEL] || st_ff.slow_cnt == lfb_pkg::SLOW_DIV_LAST);
      // Five bits so code 15 does not wrap to a zero divisor
      fd_plus = {1'b0, fd_code} + 5'h01;
      // Drive divisor per multiplex level and divider code
      if (mux == lfb_pkg::MUX_3 || mux == lfb_pkg::MUX_4) begin
         if (fd_code == 4'h0) begin
            drive_div = lfb_pkg::DIV0_MUX34; // [RL15] [RL18]
         end else if (mux == lfb_pkg::MUX_3 && fd_code == 4'h1) begin
            drive_div = lfb_pkg::DIV1_MUX3; // [RL18]
         end else begin
            drive_div = {2'b00, fd_plus, 1'b0}; // [RL15] [RL18]
         end
      end else begin
         if (fd_code == 4'h0) begin
            drive_div = lfb_pkg::DIV0_MUX2; // [RL14]
         end else begin
            drive_div = {1'b0, fd_plus, 2'b00}; // [RL14]
         end
      end
      // Drive ticks per frame equal the number of commons, except three-way code 1, which takes two
      unique case (mux)
         lfb_pkg::MUX_4: last_phase = 2'd3; // [RL15]
         lfb_pkg::MUX_3: begin
            // Code 1 frames after two drive steps
            if (fd_code == 4'h1) begin
               last_phase = 2'd1; // [RL18]
            end else begin
               last_phase = 2'd2; // [RL18]
            end
         end
         default:        last_phase = 2'd1; // [RL14]
      endcase
      if (st_ff.clkblk[lfb_pkg::CB_SRC_HI:lfb_pkg::CB_SRC_LO] == lfb_pkg::BLK_FIXED) begin
         blk_half = lfb_pkg::BLK_HALF_2HZ; // [RL10]
      end else begin
         unique case (st_ff.clkblk[lfb_pkg::CB_RATE_HI:lfb_pkg::CB_RATE_LO]) // [RL11] [RL12]
            2'b00: blk_half = lfb_pkg::BLK_HALF_1HZ;
            2'b01: blk_half = lfb_pkg::BLK_HALF_H2HZ;
            2'b10: blk_half = lfb_pkg::BLK_HALF_H3HZ;
            2'b11: blk_half = lfb_pkg::BLK_HALF_H4HZ;
         endcase
      end
   end

   // APB decode
   always_comb begin
      setup  = psel & ~penable;
      access = psel & penable & st_ff.pready;
      hit    = 1'b1;
      rd_val = 8'h00;
      unique case (paddr)
         lfb_pkg::ADDR_PRIMARY: rd_val = st_ff.primary;
         lfb_pkg::ADDR_CLKBLK:  rd_val = st_ff.clkblk;
         lfb_pkg::ADDR_FRMUPD:  rd_val = st_ff.frmupd;
         lfb_pkg::ADDR_STATUS:  rd_val = {6'h00, st_ff.stat};
         lfb_pkg::ADDR_MASK:    rd_val = {6'h00, st_ff.mask};
         default:               hit = 1'b0;
      endcase
   end

   always_comb begin
      nxt_st = st_ff;
      nxt_st.drv.drive_tick  = 1'b0;
      nxt_st.drv.frame_start = 1'b0;
      nxt_st.drv.load_strobe = 1'b0;

      // Bus: one wait-free access phase after each setup
      if (setup) begin
         nxt_st.pready  = 1'b1;
         nxt_st.pslverr = ~hit;
         nxt_st.prdata  = {24'h00_0000, rd_val};
      end else if (access) begin
         nxt_st.pready  = 1'b0;
         nxt_st.pslverr = 1'b0;
         if (pwrite) begin
            unique case (paddr)
               lfb_pkg::ADDR_PRIMARY: nxt_st.primary = pwdata[7:0] & lfb_pkg::PC_WMASK;
               lfb_pkg::ADDR_CLKBLK:  nxt_st.clkblk = pwdata[7:0]; // [RL13]
               lfb_pkg::ADDR_FRMUPD: begin
                  // Reserved bits dropped; flag only cleared by writing zero
                  nxt_st.frmupd = (pwdata[7:0] & lfb_pkg::FU_WMASK) |
                                  {6'h00, st_ff.frmupd[lfb_pkg::FU_UPD] & pwdata[lfb_pkg::FU_UPD], 1'b0}; // [RL1] [RL3]
               end
               lfb_pkg::ADDR_MASK:    nxt_st.mask = pwdata[1:0];
               default: ;
            endcase
         end else if (paddr == lfb_pkg::ADDR_STATUS) begin
            nxt_st.stat = 2'b00;
         end
      end
      nxt_st.drv.mem_hold = nxt_st.frmupd[lfb_pkg::FU_HOLD];

      // LCD base clock
      if (base_tick) begin
         nxt_st.pre_cnt  = 15'h0000;
         nxt_st.slow_cnt = st_ff.slow_cnt + 4'h1;
      end else begin
         nxt_st.pre_cnt = st_ff.pre_cnt + 15'h0001;
      end

      // Drive divider; >= keeps a shrinking divisor from overrunning
      if (lcd_tick) begin
         if (st_ff.div_cnt >= drive_div - 8'h01) begin
            nxt_st.div_cnt = 8'h00;
            nxt_st.drv.drive_tick = 1'b1; // [RL13]
         end else begin
            nxt_st.div_cnt = st_ff.div_cnt + 8'h01;
         end
      end

      // Hold defers any load until after the release
      if (st_ff.frmupd[lfb_pkg::FU_HOLD]) begin
         nxt_st.load_pend = 1'b1; // [RL5]
      end

      if (nxt_st.drv.drive_tick) begin
         if (st_ff.drv.com_phase >= last_phase) begin
            nxt_st.drv.com_phase   = 2'd0;
            nxt_st.drv.frame_start = 1'b1;
            nxt_st.stat[lfb_pkg::ST_FRAME] = 1'b1;
            nxt_st.drv.frame_invert = st_ff.frmupd[lfb_pkg::FU_INV] & ~st_ff.drv.frame_invert; // [RL2]
            if (!st_ff.frmupd[lfb_pkg::FU_HOLD]) begin
               nxt_st.drv.load_strobe = 1'b1; // [RL5] [RL6]
               if (st_ff.load_pend) begin
                  nxt_st.load_pend = 1'b0;
                  nxt_st.frmupd[lfb_pkg::FU_UPD] = 1'b1; // [RL4]
                  nxt_st.stat[lfb_pkg::ST_UPD]   = 1'b1;
               end
            end
         end else begin
            nxt_st.drv.com_phase = st_ff.drv.com_phase + 2'd1;
         end
      end

      // Clearing the enable ends inversion at once, not a frame later
      if (!st_ff.frmupd[lfb_pkg::FU_INV]) begin
         nxt_st.drv.frame_invert = 1'b0; // [RL2]
      end

      // Blink pacing on the 2048 Hz base
      if (base_tick) begin
         if (st_ff.blk_cnt >= blk_half - 13'h0001) begin
            nxt_st.blk_cnt   = 13'h0000;
            nxt_st.blk_phase = ~st_ff.blk_phase;
         end else begin
            nxt_st.blk_cnt = st_ff.blk_cnt + 13'h0001;
         end
      end
      if (!st_ff.primary[lfb_pkg::PC_BLINK]) begin
         nxt_st.drv.display_on = 1'b1; // [RL17]
      end else begin
         unique case (st_ff.clkblk[lfb_pkg::CB_SRC_HI:lfb_pkg::CB_SRC_LO])
            lfb_pkg::BLK_SW_OFF: nxt_st.drv.display_on = 1'b0; // [RL8]
            lfb_pkg::BLK_SW_ON:  nxt_st.drv.display_on = 1'b1; // [RL9]
            default:             nxt_st.drv.display_on = ~st_ff.blk_phase; // [RL10] [RL11]
         endcase
      end

      nxt_st.irq = |(nxt_st.stat & nxt_st.mask);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff         <= '0;
         st_ff.frmupd  <= lfb_pkg::RST_FRMUPD;
         st_ff.clkblk  <= lfb_pkg::RST_CLKBLK;
         st_ff.primary <= lfb_pkg::RST_PRIMARY;
         st_ff.mask    <= lfb_pkg::RST_MASK;
         st_ff.drv.display_on <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign prdata  = st_ff.prdata;
   assign pready  = st_ff.pready;
   assign pslverr = st_ff.pslverr;
   assign drive   = st_ff.drv;
   assign irq     = st_ff.irq;
endmodule
`default_nettype wire

// ### verif/lfb_ctrl_assertions.sv
// Purpose: Port checks for lfb_ctrl
// Assumes: Single pclk domain
// Notes:   Helper flops mirror the written config
`timescale 1ns/1ps
`default_nettype none
module lfb_ctrl_assertions (
   // Clock and reset
   input wire logic                pclk,
   input wire logic                presetn,
   // APB
   input wire logic                psel,
   input wire logic                penable,
   input wire logic                pwrite,
   input wire logic [11:0]         paddr,
   input wire logic [31:0]         pwdata,
   input wire logic                pready,
   input wire logic                pslverr,
   // Drive
   input wire lfb_pkg::lfb_drive_s drive
);
   logic       wr;
   logic       mapped;
   logic       inv_ff;
   logic       en_ff;
   logic [1:0] src_ff;
   assign wr = psel && penable && pready && pwrite;
   assign mapped = paddr inside {lfb_pkg::ADDR_PRIMARY, lfb_pkg::ADDR_CLKBLK, lfb_pkg::ADDR_FRMUPD,
                                 lfb_pkg::ADDR_STATUS, lfb_pkg::ADDR_MASK};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         inv_ff <= 1'b0;
         en_ff  <= 1'b0;
         src_ff <= 2'h0;
      end else if (wr) begin
         if (paddr == lfb_pkg::ADDR_FRMUPD) inv_ff <= pwdata[6];
         if (paddr == lfb_pkg::ADDR_PRIMARY) en_ff <= pwdata[5];
         if (paddr == lfb_pkg::ADDR_CLKBLK) src_ff <= pwdata[7:6];
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_apb_zero_wait: assert property (psel && !penable |=> pready) else $error("pready late");
   chk_ready_single: assert property (pready |=> !pready) else $error("pready held");
   chk_err_unmapped: assert property (pready |-> pslverr == !mapped) else $error("pslverr wrong");
   // Hold must be seen two cycles: the edge that sets it may still load
   chk_hold_no_load: assert property (drive.mem_hold [*2] |-> !drive.load_strobe)
      else $error("load while held");
   chk_load_on_frame: assert property (drive.load_strobe |-> drive.frame_start)
      else $error("load off frame");
   chk_frame_on_tick: assert property (drive.frame_start |-> drive.drive_tick && drive.com_phase == 2'd0)
      else $error("frame start off phase zero");
   chk_inv_off: assert property (!inv_ff [*3] |-> !drive.frame_invert)
      else $error("inverted while off");
   chk_blink_off: assert property ((en_ff && src_ff == 2'h0) [*3] |-> !drive.display_on)
      else $error("display not off");
   chk_blink_on: assert property ((en_ff && src_ff == 2'h1) [*3] |-> drive.display_on)
      else $error("display not on");
   chk_blink_gate: assert property (!en_ff [*3] |-> drive.display_on)
      else $error("blink without enable");
   cover property (drive.load_strobe);
   cover property ($rose(drive.frame_invert));
   cover property (pready && pslverr);
endmodule
bind lfb_ctrl lfb_ctrl_assertions i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
                                         .pready, .pslverr, .drive);
`default_nettype wire

// ### verif/lfb_glass_model.sv
// Purpose: Glass panel watcher on the drive outputs
// Assumes: Single pclk domain
// Notes:   Spacings are counted in pclk cycles
`timescale 1ns/1ps
`default_nettype none
module lfb_glass_model (
   // Clock and reset
   input wire logic                pclk,
   input wire logic                presetn,
   // Drive from the controller
   input wire lfb_pkg::lfb_drive_s drive,
   // Observations
   output var int                  frames,
   output var int                  loads,
   output var int                  blinks,
   output var int                  frame_len,
   output var int                  blink_len,
   output var logic                inv_seen
);
   int   cyc;
   int   t_frame;
   int   t_blink;
   logic fs_d;
   logic on_d;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {frames, loads, blinks, frame_len, blink_len, cyc, t_frame, t_blink} <= '0;
         {fs_d, inv_seen} <= 2'h0;
         on_d <= 1'b1;
      end else begin
         cyc <= cyc + 1;
         fs_d <= drive.frame_start;
         on_d <= drive.display_on;
         // Sampled a cycle late so either update style settles
         if (fs_d) inv_seen <= drive.frame_invert;
         if (drive.load_strobe) loads <= loads + 1;
         if (drive.frame_start) begin
            frames <= frames + 1;
            frame_len <= cyc - t_frame;
            t_frame <= cyc;
         end
         if (drive.display_on != on_d) begin
            blinks <= blinks + 1;
            blink_len <= cyc - t_blink;
            t_blink <= cyc;
         end
      end
   end
endmodule
`default_nettype wire

// ### verif/lfb_ctrl_tb.sv
// Purpose: Self-checking bench for lfb_ctrl
// Assumes: TICK_CYC of 4, zero-wait APB
// Notes:   Reads are queued and checked by a monitor
`timescale 1ns/1ps
`default_nettype none
module lfb_ctrl_tb;
   localparam int TC = 4;
   logic                pclk;
   logic                presetn;
   logic                psel;
   logic                penable;
   logic                pwrite;
   logic [11:0]         paddr;
   logic [31:0]         pwdata;
   logic [31:0]         prdata;
   logic                pready;
   logic                pslverr;
   logic                irq;
   lfb_pkg::lfb_drive_s drive;
   int                  frames, loads, blinks, frame_len, blink_len, n, num_errors, check_count;
   logic                inv_seen;
   logic                a;
   logic [7:0]          d;
   logic [32:0]         exp_q[$];
   lfb_ctrl #(.TICK_CYC(TC)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
                                    .prdata, .pready, .pslverr, .drive, .irq);
   lfb_glass_model i_glass (.pclk, .presetn, .drive, .frames, .loads, .blinks, .frame_len, .blink_len,
                            .inv_seen);
   always #12.5 pclk = ~pclk;
   task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results;
      if (num_errors == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Request held until pready is sampled high
   task automatic bus(input logic w, input logic [11:0] ad, input logic [7:0] wd, input logic [32:0] e);
      int i;
      if (!w) exp_q.push_back(e);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, ad, 24'h00_0000, wd};
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (!pready && i < 50);
      {psel, penable} <= 2'h0;
      if (!pready) begin
         num_errors++;
         results();
      end
   endtask
   task automatic wt(input bit b, input int cnt);
      int t;
      t = (b ? blinks : frames) + cnt;
      for (int i = 0; i < 40000; i++) begin
         @(posedge pclk);
         if ((b ? blinks : frames) >= t) return;
      end
      num_errors++;
      results();
   endtask
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite) chk({pslverr, prdata}, exp_q.pop_front());
   end
   initial begin
      logic [7:0]  pc[6] = '{8'h01, 8'h01, 8'h03, 8'h03, 8'h02, 8'h0A};
      logic [3:0]  fd[6] = '{4'h0, 4'hF, 4'h3, 4'h0, 4'h3, 4'h3};
      int          tf[6] = '{256, 128, 32, 256, 24, 384};
      logic [11:0] ra[4] = '{lfb_pkg::ADDR_PRIMARY, lfb_pkg::ADDR_CLKBLK, lfb_pkg::ADDR_FRMUPD, lfb_pkg::ADDR_MASK};
      {pclk, presetn, psel, penable, pwrite, paddr, pwdata, num_errors, check_count} = '0;
      void'($urandom(32'h8eae_2107));
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      foreach (ra[k]) bus(1'b0, ra[k], 8'h00, '0);
      bus(1'b0, 12'h000, 8'h00, {1'b1, 32'h0000_0000});
      bus(1'b0, 12'h259, 8'h00, {1'b1, 32'h0000_0000});
      repeat (3) begin
         d = 8'($urandom) | 8'h02;
         bus(1'b1, lfb_pkg::ADDR_CLKBLK, d, '0);
         bus(1'b0, lfb_pkg::ADDR_CLKBLK, 8'h00, 33'(d));
      end
      for (int k = 0; k < 6; k++) begin
         bus(1'b1, lfb_pkg::ADDR_PRIMARY, pc[k], '0);
         bus(1'b1, lfb_pkg::ADDR_CLKBLK, {4'h0, fd[k]}, '0);
         wt(1'b0, 3);
         chk(33'(frame_len), 33'(tf[k] * TC));
      end
      // Source first, so any toggle from the enable is counted before the wait
      bus(1'b1, lfb_pkg::ADDR_CLKBLK, 8'hC0, '0);
      bus(1'b1, lfb_pkg::ADDR_PRIMARY, 8'h21, '0);
      for (int k = 0; k < 5; k++) begin
         bus(1'b1, lfb_pkg::ADDR_CLKBLK, k == 4 ? 8'h80 : {2'h3, 2'(k), 4'h0}, '0);
         wt(1'b1, 2);
         chk(33'(blink_len), 33'(TC * lfb_pkg::LCD_BASE_HZ / (k == 4 ? 4 : 2) * (k == 4 ? 1 : k + 1)));
      end
      for (int k = 0; k < 3; k++) begin
         bus(1'b1, lfb_pkg::ADDR_PRIMARY, k == 1 ? 8'h01 : 8'h21, '0);
         bus(1'b1, lfb_pkg::ADDR_CLKBLK, k == 2 ? 8'h4F : 8'h0F, '0);
         repeat (4) @(posedge pclk);
         chk(33'(drive.display_on), 33'(k != 0));
      end
      bus(1'b1, lfb_pkg::ADDR_FRMUPD, 8'h41, '0);
      wt(1'b0, 1);
      n = loads;
      a = inv_seen;
      wt(1'b0, 2);
      chk(33'(loads), 33'(n));
      chk(33'(inv_seen), 33'(a));
      wt(1'b0, 1);
      chk(33'(inv_seen), 33'(!a));
      bus(1'b1, lfb_pkg::ADDR_MASK, 8'h01, '0);
      bus(1'b0, lfb_pkg::ADDR_STATUS, 8'h00, 33'(8'h02));
      bus(1'b1, lfb_pkg::ADDR_FRMUPD, 8'h40, '0);
      wt(1'b0, 1);
      repeat (2) @(posedge pclk);
      chk(33'(loads), 33'(n + 1));
      chk(33'(irq), 33'(1'b1));
      bus(1'b0, lfb_pkg::ADDR_FRMUPD, 8'h00, 33'(8'h42));
      bus(1'b0, lfb_pkg::ADDR_STATUS, 8'h00, 33'(8'h03));
      bus(1'b0, lfb_pkg::ADDR_STATUS, 8'h00, '0);
      repeat (2) @(posedge pclk);
      chk(33'(irq), '0);
      bus(1'b1, lfb_pkg::ADDR_FRMUPD, 8'h00, '0);
      bus(1'b0, lfb_pkg::ADDR_FRMUPD, 8'h00, '0);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      bus(1'b0, lfb_pkg::ADDR_CLKBLK, 8'h00, '0);
      results();
   end
endmodule
`default_nettype wire
